// ### rtl/adcdsl_pkg.sv
package adcdsl_pkg;
	// Register word indices; 0x201 is not a multiple of four, so offsets are indices
	localparam logic [11:0] DITHER_CONTROL_IDX = 12'h09d;
	localparam logic [11:0] SAMPLE_MARKER_CONTROL_IDX = 12'h160;
	localparam logic [11:0] SERIAL_LINK_ENABLE_IDX = 12'h200;
	localparam logic [11:0] SERIAL_LINK_MODE_IDX = 12'h201;
	localparam logic [11:0] AUX_CONTROL_IDX = 12'h300;
	localparam logic [11:0] LINK_STATUS_IDX = 12'h301;
	// Reset values
	localparam logic [7:0] DITHER_CONTROL_RST = 8'h00;
	localparam logic [7:0] SAMPLE_MARKER_CONTROL_RST = 8'h00;
	localparam logic [7:0] SERIAL_LINK_ENABLE_RST = 8'h01;
	localparam logic [7:0] SERIAL_LINK_MODE_RST = 8'h00;
	localparam logic [7:0] AUX_CONTROL_RST = 8'h00;
	// Field positions
	localparam int DITHER_ENABLE_BIT = 0;
	localparam int DITHER_AMPLITUDE_BIT = 1;
	localparam int ROUNDING_ERROR_BIT = 2;
	localparam int TIMESTAMP_INSERT_BIT = 0;
	localparam int LINK_ENABLE_BIT = 0;
	localparam int CAL_ENABLE_BIT = 0;
	localparam int TIMESTAMP_RECEIVER_BIT = 1;
	localparam int MODE_MSB = 5;
	// Fixed pipeline depth of converter sample path, in sample clocks
	localparam int SAMPLE_PATH_LATENCY = 4;
	localparam int LMFC_WIDTH = 8;
endpackage

// ### rtl/adcdsl_delay_line.sv
`timescale 1ns/100ps
module adcdsl_delay_line #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	// Data
	input wire logic enable_in,
	input wire logic [WIDTH-1:0] data_in,
	output logic [WIDTH-1:0] data_out
);
	logic [WIDTH-1:0] stage_ff [DEPTH];
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				stage_ff[i] <= '0;
			end
		end else if (enable_in) begin
			stage_ff[0] <= data_in;
			for (int i = 1; i < DEPTH; i++) begin
				stage_ff[i] <= stage_ff[i-1];
			end
		end
	end
	assign data_out = stage_ff[DEPTH-1];
endmodule

// ### rtl/adcdsl_top.sv
// Function
// - Dither reaches converter cores only while dither enable bit is set.
// - Dither amplitude bit: zero small amplitude, one large amplitude.
// - Rounding error select: zero into noise, one into offset and spurs.
// - Timestamp insert puts timestamp input on link field least significant bit.
// - Timestamp path latency equals converter sample path latency.
// - Wider link field: marker takes its own LSB, sample kept intact.
// - Lane alignment sequence always reports zero control bits.
// - Link enable bit zero disables, one enables; resets to one.
// - Link disabled holds link reset, serializers down, link clocks gated.
// - Link disabled holds frame counter in reset; sysref ignored.
// - Six-bit mode field selects link output mode.
`timescale 1ns/100ps
module adcdsl_top #(
	parameter int ADC_WIDTH = 12,
	parameter int LINK_WIDTH = 16,
	parameter int LATENCY = adcdsl_pkg::SAMPLE_PATH_LATENCY
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [13:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Sample path
	input wire logic sample_valid_in,
	input wire logic [ADC_WIDTH-1:0] sample_in,
	input wire logic timestamp_pin_in,
	input wire logic sysref_pin_in,
	input wire logic ila_active_in,
	output logic [LINK_WIDTH-1:0] link_sample_out,
	output logic link_sample_valid_out,
	output logic ila_control_bits_out,
	// Converter core controls
	output logic dither_enable_out,
	output logic dither_amplitude_select_out,
	output logic rounding_error_select_out,
	output logic calibration_enable_out,
	output logic timestamp_receiver_enable_out,
	// Link subsystem controls
	output logic link_reset_n_out,
	output logic serializer_power_down_out,
	output logic link_clock_enable_out,
	output logic [5:0] serial_link_mode_out,
	output logic [adcdsl_pkg::LMFC_WIDTH-1:0] lmfc_count_out
);
	typedef struct packed {
		logic [7:0] dither_control;
		logic [7:0] sample_marker_control;
		logic [7:0] serial_link_enable;
		logic [7:0] serial_link_mode;
		logic [7:0] aux_control;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [2:0] ts_sync;
		logic [2:0] sysref_sync;
		logic [LINK_WIDTH-1:0] link_sample;
		logic link_valid;
		logic [adcdsl_pkg::LMFC_WIDTH-1:0] lmfc;
		logic serializer_down;
	} adcdsl_state_type;

	adcdsl_state_type state_ff;
	adcdsl_state_type nxt_state;
	logic [ADC_WIDTH-1:0] sample_dly;
	logic valid_dly;
	logic ts_dly;
	logic [11:0] reg_index;
	logic access_phase;
	logic link_on;

	assign reg_index = paddr_in[13:2];
	assign access_phase = psel_in && penable_in && !state_ff.pready;
	assign link_on = state_ff.serial_link_enable[adcdsl_pkg::LINK_ENABLE_BIT];

	// Sample path: full pipeline depth, then the output register
	adcdsl_delay_line #(
		.WIDTH(ADC_WIDTH + 1),
		.DEPTH(LATENCY)
	) u_sample_delay (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.enable_in(1'b1),
		.data_in({sample_valid_in, sample_in}),
		.data_out({valid_dly, sample_dly})
	);

	// Two sync flops already count toward the marker's latency
	adcdsl_delay_line #(
		.WIDTH(1),
		.DEPTH(LATENCY - 2)
	) u_marker_delay (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.enable_in(1'b1),
		.data_in(state_ff.ts_sync[1]),
		.data_out(ts_dly)
	);

	always_comb begin
		nxt_state = state_ff;
		nxt_state.pready = 1'b0;
		nxt_state.pslverr = 1'b0;
		// Two-stage sync of pins; third stage for sysref edge detect
		nxt_state.ts_sync = {state_ff.ts_sync[1:0], timestamp_pin_in};
		nxt_state.sysref_sync = {state_ff.sysref_sync[1:0], sysref_pin_in};
		// One wait state: answer in the cycle after the first access cycle
		if (access_phase) begin
			nxt_state.pready = 1'b1;
			nxt_state.prdata = 32'h0000_0000;
			if (pwrite_in) begin
				case (reg_index)
					adcdsl_pkg::DITHER_CONTROL_IDX:
						nxt_state.dither_control = pwdata_in[7:0];
					adcdsl_pkg::SAMPLE_MARKER_CONTROL_IDX:
						nxt_state.sample_marker_control = pwdata_in[7:0];
					adcdsl_pkg::SERIAL_LINK_ENABLE_IDX:
						nxt_state.serial_link_enable = pwdata_in[7:0];
					adcdsl_pkg::SERIAL_LINK_MODE_IDX:
						nxt_state.serial_link_mode = pwdata_in[7:0];
					adcdsl_pkg::AUX_CONTROL_IDX:
						nxt_state.aux_control = pwdata_in[7:0];
					adcdsl_pkg::LINK_STATUS_IDX: begin
						nxt_state.pslverr = 1'b1;
					end
					default: begin
						nxt_state.pslverr = 1'b1;
					end
				endcase
			end else begin
				case (reg_index)
					adcdsl_pkg::DITHER_CONTROL_IDX:
						nxt_state.prdata = {24'h000000, state_ff.dither_control};
					adcdsl_pkg::SAMPLE_MARKER_CONTROL_IDX:
						nxt_state.prdata = {24'h000000, state_ff.sample_marker_control};
					adcdsl_pkg::SERIAL_LINK_ENABLE_IDX:
						nxt_state.prdata = {24'h000000, state_ff.serial_link_enable};
					adcdsl_pkg::SERIAL_LINK_MODE_IDX:
						nxt_state.prdata = {24'h000000, state_ff.serial_link_mode};
					adcdsl_pkg::AUX_CONTROL_IDX:
						nxt_state.prdata = {24'h000000, state_ff.aux_control};
					adcdsl_pkg::LINK_STATUS_IDX:
						nxt_state.prdata = {16'h0000, state_ff.lmfc, 7'h00, link_on};
					default: begin
						nxt_state.pslverr = 1'b1;
					end
				endcase
			end
		end
		// Frame counter frozen at zero while link is off; sysref ignored then
		if (!link_on) begin
			nxt_state.lmfc = '0;
		end else if (state_ff.sysref_sync[1] && !state_ff.sysref_sync[2]) begin
			nxt_state.lmfc = '0;
		end else begin
			nxt_state.lmfc = state_ff.lmfc + 1'b1;
		end
		// Transport mapping: sample left-justified, marker in field LSB
		nxt_state.link_valid = valid_dly && link_on;
		nxt_state.link_sample = '0;
		nxt_state.link_sample[LINK_WIDTH-1 -: ADC_WIDTH] = sample_dly;
		if (state_ff.sample_marker_control[adcdsl_pkg::TIMESTAMP_INSERT_BIT]) begin
			nxt_state.link_sample[0] = ts_dly;
		end
		if (!link_on) begin
			nxt_state.link_sample = '0;
		end
		// Kept as its own flop so the pin is not an inverter output
		nxt_state.serializer_down = !nxt_state.serial_link_enable[adcdsl_pkg::LINK_ENABLE_BIT];
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_ff <= '0;
			state_ff.dither_control <= adcdsl_pkg::DITHER_CONTROL_RST;
			state_ff.sample_marker_control <= adcdsl_pkg::SAMPLE_MARKER_CONTROL_RST;
			state_ff.serial_link_enable <= adcdsl_pkg::SERIAL_LINK_ENABLE_RST;
			state_ff.serial_link_mode <= adcdsl_pkg::SERIAL_LINK_MODE_RST;
			state_ff.aux_control <= adcdsl_pkg::AUX_CONTROL_RST;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign prdata_out = state_ff.prdata;
	assign pready_out = state_ff.pready;
	assign pslverr_out = state_ff.pslverr;
	assign link_sample_out = state_ff.link_sample;
	assign link_sample_valid_out = state_ff.link_valid;
	// Alignment sequence never advertises control bits
	assign ila_control_bits_out = 1'b0;
	assign dither_enable_out = state_ff.dither_control[adcdsl_pkg::DITHER_ENABLE_BIT];
	assign dither_amplitude_select_out =
		state_ff.dither_control[adcdsl_pkg::DITHER_AMPLITUDE_BIT];
	assign rounding_error_select_out =
		state_ff.dither_control[adcdsl_pkg::ROUNDING_ERROR_BIT];
	assign calibration_enable_out = state_ff.aux_control[adcdsl_pkg::CAL_ENABLE_BIT];
	assign timestamp_receiver_enable_out =
		state_ff.aux_control[adcdsl_pkg::TIMESTAMP_RECEIVER_BIT];
	assign link_reset_n_out = link_on;
	assign serializer_power_down_out = state_ff.serializer_down;
	assign link_clock_enable_out = link_on;
	assign serial_link_mode_out = state_ff.serial_link_mode[adcdsl_pkg::MODE_MSB:0];
	assign lmfc_count_out = state_ff.lmfc;
endmodule

// ### dv/adcdsl_chk_sva.sv
`timescale 1ns/100ps
module adcdsl_chk #(parameter int LINK_WIDTH = 16) (
	// Clock, reset, bus
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [13:0] paddr_in,
	input wire logic pready_out,
	// Observed outputs
	input wire logic [LINK_WIDTH-1:0] link_sample_out,
	input wire logic link_sample_valid_out,
	input wire logic ila_control_bits_out,
	input wire logic dither_enable_out,
	input wire logic link_reset_n_out,
	input wire logic serializer_power_down_out,
	input wire logic link_clock_enable_out,
	input wire logic [5:0] serial_link_mode_out,
	input wire logic [7:0] lmfc_count_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);
	wire logic acc_wr = psel_in && penable_in && pwrite_in;
	property p_pins; link_clock_enable_out == link_reset_n_out && serializer_power_down_out != link_reset_n_out; endproperty
	a_pins: assert property (p_pins) else $error("link control pins disagree");
	// Two cycles off allows one stage of skew between control and data registers
	property p_valid_off; !link_reset_n_out [*2] |-> !link_sample_valid_out; endproperty
	a_valid_off: assert property (p_valid_off) else $error("valid while link off");
	property p_data_off; !link_reset_n_out [*2] |-> link_sample_out == '0; endproperty
	a_data_off: assert property (p_data_off) else $error("data while link off");
	property p_lmfc_off; !link_reset_n_out [*2] |-> lmfc_count_out == 8'h00; endproperty
	a_lmfc_off: assert property (p_lmfc_off) else $error("frame counter runs while off");
	property p_ila; ila_control_bits_out == 1'b0; endproperty
	a_ila: assert property (p_ila) else $error("alignment control bits not zero");
	property p_ready; pready_out |=> !pready_out; endproperty
	a_ready: assert property (p_ready) else $error("ready longer than one cycle");
	property p_mode; !$stable(serial_link_mode_out) |-> $past(acc_wr && paddr_in == 14'h804); endproperty
	a_mode: assert property (p_mode) else $error("mode changed without write");
	property p_dith; !$stable(dither_enable_out) |-> $past(acc_wr && paddr_in == 14'h274); endproperty
	a_dith: assert property (p_dith) else $error("dither changed without write");
endmodule
bind adcdsl_top adcdsl_chk #(.LINK_WIDTH(LINK_WIDTH)) chk_u (.sys_clk_in, .reset_n_in,
	.psel_in, .penable_in, .pwrite_in, .paddr_in, .pready_out, .link_sample_out,
	.link_sample_valid_out, .ila_control_bits_out, .dither_enable_out, .link_reset_n_out,
	.serializer_power_down_out, .link_clock_enable_out, .serial_link_mode_out, .lmfc_count_out);

// ### dv/tb.sv
`timescale 1ns/100ps
module tb;
	logic sys_clk_in = 1'b0, reset_n_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0;
	logic pwrite_in = 1'b0, sample_valid_in = 1'b0, timestamp_pin_in = 1'b0;
	logic sysref_pin_in = 1'b0, ila_active_in = 1'b0, rd_err;
	logic [13:0] paddr_in = 14'h0000;
	logic [31:0] pwdata_in = 32'h0, prdata_out, rd_data, seed = 32'h0b69;
	logic [11:0] sample_in = 12'h000;
	logic [15:0] link_sample_out;
	logic [5:0] serial_link_mode_out;
	logic [7:0] lmfc_count_out;
	logic pready_out, pslverr_out, link_sample_valid_out, ila_control_bits_out;
	logic dither_enable_out, dither_amplitude_select_out, rounding_error_select_out;
	logic calibration_enable_out, timestamp_receiver_enable_out, link_reset_n_out;
	logic serializer_power_down_out, link_clock_enable_out;
	int err_count = 0, num_checks = 0;
	logic [13:0] addrs [5] = '{14'h274, 14'h580, 14'h800, 14'h804, 14'hc00};
	// Reserved bits zero; link enable written 0 so mode may change
	logic [31:0] msk [4] = '{32'h7, 32'h1, 32'h0, 32'h3f};
	always #2 sys_clk_in = ~sys_clk_in;
	adcdsl_top dut_u (.sys_clk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
		.pwdata_in, .prdata_out, .pready_out, .pslverr_out, .sample_valid_in, .sample_in,
		.timestamp_pin_in, .sysref_pin_in, .ila_active_in, .link_sample_out,
		.link_sample_valid_out, .ila_control_bits_out, .dither_enable_out,
		.dither_amplitude_select_out, .rounding_error_select_out, .calibration_enable_out,
		.timestamp_receiver_enable_out, .link_reset_n_out, .serializer_power_down_out,
		.link_clock_enable_out, .serial_link_mode_out, .lmfc_count_out);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge sys_clk_in);
		penable_in <= 1'b1;
		@(posedge sys_clk_in);
		while (pready_out !== 1'b1 && n < 50) begin
			n++;
			@(posedge sys_clk_in);
		end
		if (n >= 50)
			err_count++;
		rd_data = prdata_out;
		rd_err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task end_sim;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge sys_clk_in);
		err_count++;
		end_sim();
	end
	initial begin
		repeat (8) @(posedge sys_clk_in);
		reset_n_in <= 1'b1;
		chk({link_reset_n_out, serializer_power_down_out}, 2'b10);
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, addrs[i], 32'h0);
			chk(rd_data, (i == 2) ? 32'h1 : 32'h0);
		end
		for (int k = 0; k < 12; k++) begin
			seed = lfsr(seed);
			apb(1'b1, addrs[k % 4], seed & msk[k % 4]);
			apb(1'b0, addrs[k % 4], 32'h0);
			chk(rd_data, seed & msk[k % 4]);
			if (k % 4 == 0)
				chk({rounding_error_select_out, dither_amplitude_select_out, dither_enable_out}, seed[2:0]);
			if (k % 4 == 3)
				chk(serial_link_mode_out, seed[5:0]);
		end
		// Unmapped place and read-only status both refused
		apb(1'b0, 14'h0004, 32'h0);
		chk(rd_err, 1'b1);
		chk(rd_data, 32'h0);
		apb(1'b1, 14'hc04, 32'hff);
		chk(rd_err, 1'b1);
		apb(1'b1, 14'h800, 32'h0);
		sysref_pin_in <= 1'b1;
		sample_valid_in <= 1'b1;
		repeat (6) @(posedge sys_clk_in);
		chk({link_reset_n_out, link_clock_enable_out, serializer_power_down_out}, 3'b001);
		chk({link_sample_valid_out, link_sample_out, lmfc_count_out}, 32'h0);
		apb(1'b1, 14'hc00, 32'h3);
		chk({calibration_enable_out, timestamp_receiver_enable_out}, 2'b11);
		apb(1'b1, 14'h800, 32'h1);
		apb(1'b1, 14'h580, 32'h1);
		seed = lfsr(seed);
		sample_in <= seed[11:0];
		timestamp_pin_in <= 1'b1;
		repeat (9) @(posedge sys_clk_in);
		chk({link_sample_valid_out, link_sample_out}, {1'b1, seed[11:0], 4'h1});
		chk(ila_control_bits_out, 1'b0);
		apb(1'b1, 14'h580, 32'h0);
		repeat (9) @(posedge sys_clk_in);
		chk(link_sample_out, {seed[11:0], 4'h0});
		// Sysref edge while enabled restarts the frame counter
		sysref_pin_in <= 1'b0;
		repeat (4) @(posedge sys_clk_in);
		sysref_pin_in <= 1'b1;
		repeat (5) @(posedge sys_clk_in);
		@(negedge sys_clk_in);
		chk(lmfc_count_out, 32'h2);
		end_sim();
	end
endmodule
